// File: verilog/dmc_pkg.sv
// Constants for the DMA control, ownership and host reset block.
// Assumes a single core clock and two register access ports.
package dmc_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] DMC_OFF_LOCAL_ADDR = 12'h4b0;
  localparam logic [11:0] DMC_OFF_HOST_ADDR = 12'h4b4;
  localparam logic [11:0] DMC_OFF_LENGTH = 12'h4b8;
  localparam logic [11:0] DMC_OFF_CONTROL = 12'h4bc;
  localparam logic [11:0] DMC_OFF_SEMAPHORE = 12'h4c0;
  localparam logic [11:0] DMC_OFF_HOST_RESET = 12'h4e0;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int DMC_LEN_LSB = 2;
  localparam int DMC_LEN_MSB = 13;
  localparam int DMC_CTL_DIR = 0;
  localparam int DMC_CTL_PFI = 1;
  localparam int DMC_CTL_PCI_OWN = 8;
  localparam int DMC_CTL_LOC_OWN = 9;
  localparam int DMC_HRC_CPU_RST = 0;
  localparam int DMC_HRC_SOFT_RST = 1;
  localparam logic [31:0] DMC_SEM_PCI_MASK = 32'h0101_0101;
  localparam logic [31:0] DMC_SEM_LOC_MASK = 32'h0202_0202;
  // ****************************************
  // PCI read and write commands and reset values
  // ****************************************
  localparam logic [3:0] DMC_CMD_MEM_READ = 4'h6;
  localparam logic [3:0] DMC_CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] DMC_CMD_READ_LINE = 4'hc;
  localparam logic [3:0] DMC_CMD_READ_MULT = 4'he;
  localparam logic [11:0] DMC_LINE_DWORDS = 12'h008;
  localparam logic [31:0] DMC_RST_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    DMC_IDLE = 2'b00,
    DMC_XFER = 2'b01,
    DMC_DONE = 2'b10
  } dmc_state_e;
endpackage : dmc_pkg

// File: verilog/dmc_sem_pair.sv
// One local/PCI ownership flag pair.
// Assumes write strobes come from the same clock domain.
`timescale 1ns/1ps
module dmc_sem_pair (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_soft_rst,
  input wire logic i_loc_we,
  input wire logic i_loc_d,
  input wire logic i_pci_we,
  input wire logic i_pci_d,
  output logic o_loc_own,
  output logic o_pci_own
);
  // ****************************************
  // Paired flags
  // ****************************************
  // Same-clock collision: the earlier owner wins; if both free, PCI wins
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || (i_ce && i_soft_rst)) begin
      o_loc_own <= 1'b0;
      o_pci_own <= 1'b0;
    end else if (i_ce) begin
      if (i_loc_we && !o_pci_own && !(i_pci_we && i_pci_d && !o_loc_own)) begin
        o_loc_own <= i_loc_d;
      end
      if (i_pci_we && !o_loc_own) begin
        o_pci_own <= i_pci_d;
      end
    end
  end
endmodule : dmc_sem_pair

// File: verilog/dmc_top.sv
// DMA control, ownership semaphores and host reset control.
// Assumes local and PCI register ports are synchronous to i_core_clk;
// the bus-master engine outside handshakes data phases by i_dphase.
`timescale 1ns/1ps
module dmc_top
  import dmc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_loc_wr,
  input wire logic i_loc_rd,
  input wire logic [11:0] i_loc_addr,
  input wire logic [3:0] i_loc_be,
  input wire logic [31:0] i_loc_wdata,
  output logic [31:0] o_loc_rdata,
  input wire logic i_pci_wr,
  input wire logic i_pci_rd,
  input wire logic [11:0] i_pci_addr,
  input wire logic [3:0] i_pci_be,
  input wire logic [31:0] i_pci_wdata,
  output logic [31:0] o_pci_rdata,
  input wire logic i_autocfg_done,
  input wire logic i_autocfg_clear_rst,
  input wire logic i_rstout_local_unused,
  input wire logic i_dphase,
  output logic o_local_cpu_reset_out,
  output logic o_local_cpu_reset_out_n,
  output logic o_soft_reset,
  output logic o_dq_oe_n,
  output logic o_fifo_flush,
  output logic o_mbox_event_clr,
  output logic o_xfer_busy,
  output logic o_xfer_done,
  output logic o_xfer_dir,
  output logic [3:0] o_pci_cmd,
  output logic [13:0] o_shared_addr,
  output logic [31:0] o_pci_addr
);
  import dmc_pkg::*;

  dmc_state_e state_r;
  logic [11:0] local_start_r;
  logic [29:0] host_start_r;
  logic [11:0] length_r;
  logic dir_r;
  logic pfi_r;
  logic [11:0] left_r;
  logic [11:0] shared_dw_r;
  logic [29:0] pci_dw_r;
  logic cpu_rst_r;
  logic soft_r;
  logic [3:0] sem_loc;
  logic [3:0] sem_pci;
  logic [3:0] ctl_loc_own;
  logic [3:0] ctl_pci_own;
  logic loc_w;
  logic pci_w;
  logic [11:0] w_addr;
  logic [3:0] w_be;
  logic [31:0] w_data;
  logic start;
  logic [3:0] sem_loc_we;
  logic [3:0] sem_pci_we;
  logic ctl_loc_we;
  logic ctl_pci_we;
  logic hrc_pci_w;
  logic hrc_loc_w;

  // ****************************************
  // Write port merge
  // ****************************************
  // Local side wins a same-cycle clash on plain registers
  assign loc_w = i_ce && i_loc_wr;
  assign pci_w = i_ce && i_pci_wr;
  assign w_addr = loc_w ? i_loc_addr : i_pci_addr;
  assign w_be = loc_w ? i_loc_be : i_pci_be;
  assign w_data = loc_w ? i_loc_wdata : i_pci_wdata;
  assign start = (loc_w || pci_w) && (w_addr == DMC_OFF_CONTROL) && w_be[0]
    && !soft_r;

  // ****************************************
  // Strobe decode per register
  // ****************************************
  // One byte lane per semaphore pair; each side decodes its own address
  assign sem_loc_we = (loc_w && i_loc_addr == DMC_OFF_SEMAPHORE) ? i_loc_be : 4'h0;
  assign sem_pci_we = (pci_w && i_pci_addr == DMC_OFF_SEMAPHORE) ? i_pci_be : 4'h0;
  // Owner bits 9:8 live in byte lane 1 of the control word
  assign ctl_loc_we = loc_w && i_loc_addr == DMC_OFF_CONTROL && i_loc_be[1];
  assign ctl_pci_we = pci_w && i_pci_addr == DMC_OFF_CONTROL && i_pci_be[1];
  // Host reset: a PCI write hides a same-cycle local one
  assign hrc_pci_w = pci_w && i_pci_addr == DMC_OFF_HOST_RESET && i_pci_be[0];
  assign hrc_loc_w = loc_w && i_loc_addr == DMC_OFF_HOST_RESET && i_loc_be[0];

  // ****************************************
  // Address and length registers
  // ****************************************
  // Soft reset returns these to defaults
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      local_start_r <= 12'h000;
      host_start_r <= 30'h0000_0000;
      length_r <= 12'h000;
    end else if (i_ce) begin
      if (soft_r) begin
        local_start_r <= 12'h000;
        host_start_r <= 30'h0000_0000;
        length_r <= 12'h000;
      end else if (loc_w || pci_w) begin
        if (w_addr == DMC_OFF_LOCAL_ADDR && w_be[1:0] != 2'b00) begin
          local_start_r <= w_data[DMC_LEN_MSB:DMC_LEN_LSB];
        end
        if (w_addr == DMC_OFF_HOST_ADDR && w_be != 4'h0) begin
          host_start_r <= w_data[31:2];
        end
        if (w_addr == DMC_OFF_LENGTH && w_be[1:0] != 2'b00) begin
          length_r <= w_data[DMC_LEN_MSB:DMC_LEN_LSB];
        end
      end
    end
  end

  // ****************************************
  // Direction and prefetch inhibit
  // ****************************************
  // Both survive soft reset
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      dir_r <= 1'b0;
      pfi_r <= 1'b0;
    end else if (i_ce && (loc_w || pci_w) && w_addr == DMC_OFF_CONTROL && w_be[0]
        && !soft_r) begin
      dir_r <= w_data[DMC_CTL_DIR];
      pfi_r <= w_data[DMC_CTL_PFI];
    end
  end

  // ****************************************
  // Ownership pairs
  // ****************************************
  // Pair 0..3 are the semaphore register; pair 4 is the control bits 9:8
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sem
      dmc_sem_pair u_pair (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_soft_rst(soft_r),
        .i_loc_we(sem_loc_we[g]),
        .i_loc_d(i_loc_wdata[8*g+1]),
        .i_pci_we(sem_pci_we[g]),
        .i_pci_d(i_pci_wdata[8*g]),
        .o_loc_own(sem_loc[g]),
        .o_pci_own(sem_pci[g])
      );
    end
  endgenerate

  dmc_sem_pair u_ctl_own (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_soft_rst(soft_r),
    .i_loc_we(ctl_loc_we),
    .i_loc_d(i_loc_wdata[DMC_CTL_LOC_OWN]),
    .i_pci_we(ctl_pci_we),
    .i_pci_d(i_pci_wdata[DMC_CTL_PCI_OWN]),
    .o_loc_own(ctl_loc_own[0]),
    .o_pci_own(ctl_pci_own[0])
  );
  assign ctl_loc_own[3:1] = 3'b000;
  assign ctl_pci_own[3:1] = 3'b000;

  // ****************************************
  // Host reset control
  // ****************************************
  // CPU reset only releasable once configuration has finished
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cpu_rst_r <= 1'b1;
      soft_r <= 1'b0;
    end else if (i_ce) begin
      if (hrc_pci_w) begin
        soft_r <= i_pci_wdata[DMC_HRC_SOFT_RST];
        if (i_autocfg_done || i_pci_wdata[DMC_HRC_CPU_RST]) begin
          cpu_rst_r <= i_pci_wdata[DMC_HRC_CPU_RST];
        end
      end else if (hrc_loc_w) begin
        soft_r <= i_loc_wdata[DMC_HRC_SOFT_RST];
        if (i_rstout_local_unused && (i_autocfg_done || i_loc_wdata[DMC_HRC_CPU_RST])) begin
          cpu_rst_r <= i_loc_wdata[DMC_HRC_CPU_RST];
        end
      end else if (i_autocfg_done && i_autocfg_clear_rst) begin
        cpu_rst_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Transfer sequencer
  // ****************************************
  // Engine counts one dword per accepted data phase
  // A start while busy is dropped: software must poll busy first
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_r <= DMC_IDLE;
      left_r <= 12'h000;
      shared_dw_r <= 12'h000;
      pci_dw_r <= 30'h0000_0000;
    end else if (i_ce) begin
      if (soft_r) begin
        state_r <= DMC_IDLE;
      end else begin
        unique case (state_r)
          DMC_IDLE: begin
            if (start) begin
              state_r <= (length_r == 12'h000) ? DMC_DONE : DMC_XFER;
              left_r <= length_r;
              shared_dw_r <= local_start_r;
              pci_dw_r <= host_start_r;
            end
          end
          DMC_XFER: begin
            if (i_dphase) begin
              left_r <= left_r - 12'h001;
              shared_dw_r <= shared_dw_r + 12'h001;
              pci_dw_r <= pci_dw_r + 30'h0000_0001;
              if (left_r == 12'h001) begin
                state_r <= DMC_DONE;
              end
            end
          end
          DMC_DONE: begin
            state_r <= DMC_IDLE;
          end
          default: begin
            state_r <= DMC_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Command choice: long reads prefer multiple, line when exactly one line (8 dwords) is left
  // Command tracks dwords left, so a long read steps down to line, then plain
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_local_cpu_reset_out <= 1'b1;
      o_local_cpu_reset_out_n <= 1'b0;
      o_soft_reset <= 1'b0;
      o_dq_oe_n <= 1'b1;
      o_fifo_flush <= 1'b1;
      o_mbox_event_clr <= 1'b0;
      o_xfer_busy <= 1'b0;
      o_xfer_done <= 1'b0;
      o_xfer_dir <= 1'b0;
      o_pci_cmd <= DMC_CMD_MEM_READ;
      o_shared_addr <= 14'h0000;
      o_pci_addr <= DMC_RST_ZERO;
    end else if (i_ce) begin
      o_local_cpu_reset_out <= cpu_rst_r;
      o_local_cpu_reset_out_n <= !cpu_rst_r;
      o_soft_reset <= soft_r;
      o_dq_oe_n <= soft_r || !i_loc_rd;
      o_fifo_flush <= soft_r;
      o_mbox_event_clr <= soft_r;
      o_xfer_busy <= (state_r == DMC_XFER) && !soft_r;
      o_xfer_done <= (state_r == DMC_DONE) && !soft_r;
      o_xfer_dir <= dir_r;
      o_shared_addr <= {shared_dw_r, 2'b00};
      o_pci_addr <= {pci_dw_r, 2'b00};
      if (dir_r) begin
        o_pci_cmd <= DMC_CMD_MEM_WRITE;
      end else if (pfi_r) begin
        o_pci_cmd <= DMC_CMD_MEM_READ;
      end else if (left_r > DMC_LINE_DWORDS) begin
        o_pci_cmd <= DMC_CMD_READ_MULT;
      end else if (left_r == DMC_LINE_DWORDS) begin
        o_pci_cmd <= DMC_CMD_READ_LINE;
      end else begin
        o_pci_cmd <= DMC_CMD_MEM_READ;
      end
    end
  end

  // ****************************************
  // Read back, one per port
  // ****************************************
  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    logic [31:0] r;
    r = DMC_RST_ZERO;
    unique case (a)
      DMC_OFF_LOCAL_ADDR: r = {18'h00000, local_start_r, 2'b00};
      DMC_OFF_HOST_ADDR: r = {host_start_r, 2'b00};
      DMC_OFF_LENGTH: r = {18'h00000, length_r, 2'b00};
      DMC_OFF_CONTROL: r = {22'h000000, ctl_loc_own[0], ctl_pci_own[0], 6'h00, pfi_r, dir_r};
      DMC_OFF_SEMAPHORE: r = {6'h00, sem_loc[3], sem_pci[3], 6'h00, sem_loc[2], sem_pci[2],
        6'h00, sem_loc[1], sem_pci[1], 6'h00, sem_loc[0], sem_pci[0]};
      DMC_OFF_HOST_RESET: r = {30'h0000_0000, soft_r, cpu_rst_r};
      default: r = DMC_RST_ZERO;
    endcase
    return r;
  endfunction : rd_mux

  // Read data held between reads; local reads return zero in soft reset
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_loc_rdata <= DMC_RST_ZERO;
      o_pci_rdata <= DMC_RST_ZERO;
    end else if (i_ce) begin
      if (i_loc_rd) begin
        o_loc_rdata <= soft_r ? DMC_RST_ZERO : rd_mux(i_loc_addr);
      end
      if (i_pci_rd) begin
        o_pci_rdata <= rd_mux(i_pci_addr);
      end
    end
  end
endmodule : dmc_top

// File: testbench/dmc_top_sva.sv
// Port checker for the DMA control, ownership and host reset block.
// Assumes one core clock with a synchronous active-low reset.
`timescale 1ns/1ps
module dmc_top_sva
  import dmc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_loc_rd,
  input wire logic i_autocfg_done,
  input wire logic [31:0] o_loc_rdata,
  input wire logic o_local_cpu_reset_out,
  input wire logic o_local_cpu_reset_out_n,
  input wire logic o_soft_reset,
  input wire logic o_dq_oe_n,
  input wire logic o_fifo_flush,
  input wire logic o_mbox_event_clr,
  input wire logic o_xfer_busy,
  input wire logic o_xfer_done,
  input wire logic o_xfer_dir,
  input wire logic [3:0] o_pci_cmd,
  input wire logic [31:0] o_pci_addr
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ****************
  // Helpers
  // ****************
  logic cfg_seen_r;
  // Configuration finished since reset; gates any clear of the CPU reset
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cfg_seen_r <= 1'b0;
    end else begin
      cfg_seen_r <= cfg_seen_r | i_autocfg_done;
    end
  end
  // Past term skips the one-cycle lag between soft state and its output
  sequence s_soft_held;
    o_soft_reset && $past(o_soft_reset);
  endsequence
  sequence s_busy_held;
    o_xfer_busy && $past(o_xfer_busy);
  endsequence
  sequence s_rd_soft;
    i_loc_rd && o_soft_reset ##1 o_soft_reset && !i_loc_rd;
  endsequence
  sequence s_rd_live;
    i_ce && i_loc_rd && !o_soft_reset ##1 !o_soft_reset;
  endsequence
  // ****************
  // Assertions
  // ****************
  a_rst_out_pair: assert property (o_local_cpu_reset_out == !o_local_cpu_reset_out_n)
    else $error("reset outputs not complementary");
  a_cpu_rst_hold: assert property (!cfg_seen_r |-> o_local_cpu_reset_out)
    else $error("cpu reset dropped before configuration");
  a_soft_dq_float: assert property (s_soft_held |-> o_dq_oe_n)
    else $error("data bus driven in soft reset");
  a_soft_flush: assert property (s_soft_held |-> o_fifo_flush && o_mbox_event_clr)
    else $error("flush or mailbox clear missing");
  a_soft_idle: assert property (s_soft_held |-> !o_xfer_busy)
    else $error("transfer busy in soft reset");
  a_soft_rd_zero: assert property (s_rd_soft |=> o_loc_rdata == DMC_RST_ZERO)
    else $error("local read in soft reset not zero");
  a_addr_step: assert property (s_busy_held and $changed(o_pci_addr) |->
    o_pci_addr == $past(o_pci_addr) + 32'h4)
    else $error("pci address step not one dword");
  a_done_pulse: assert property (o_xfer_done |=> !o_xfer_done)
    else $error("done longer than one cycle");
  a_write_cmd: assert property (s_busy_held and o_xfer_dir |-> o_pci_cmd == DMC_CMD_MEM_WRITE)
    else $error("write transfer wrong command");
  a_read_cmd: assert property (s_busy_held and !o_xfer_dir |->
    o_pci_cmd inside {DMC_CMD_MEM_READ, DMC_CMD_READ_LINE, DMC_CMD_READ_MULT})
    else $error("read transfer wrong command");
  a_rd_dq_drive: assert property (s_rd_live |-> !o_dq_oe_n)
    else $error("local read left data bus floating");
endmodule : dmc_top_sva
bind dmc_top dmc_top_sva u_sva (.*);

// File: testbench/dmc_engine_model.sv
// Stand-in for the bus-master engine that accepts data phases.
// Assumes busy from the block and the dword count from the bench.
`timescale 1ns/1ps
module dmc_engine_model (
  input wire logic i_core_clk,
  input wire logic i_busy,
  input wire logic [11:0] i_len,
  input wire logic [3:0] i_gap,
  output logic o_dphase
);
  int n_done;
  int wait_cnt;
  logic pulse;
  initial begin
    o_dphase = 1'b0;
    n_done = 0;
    wait_cnt = 0;
  end
  // One pulse per dword, gap idle cycles apart, none past the length
  always @(posedge i_core_clk) begin
    #1;
    pulse = i_busy && (n_done < i_len) && (wait_cnt >= i_gap);
    if (!i_busy) begin
      n_done = 0;
      wait_cnt = 0;
    end else if (pulse) begin
      n_done++;
      wait_cnt = 0;
    end else begin
      wait_cnt++;
    end
    o_dphase = pulse;
  end
endmodule : dmc_engine_model

// File: testbench/dmc_top_tb.sv
// Self-checking bench for the DMA control and reset block.
// Assumes the checker binds itself; the engine model paces data phases.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module dmc_top_tb;
  import dmc_pkg::*;
  logic i_core_clk = 0, i_rst_n = 0, i_ce = 1, i_loc_wr = 0, i_loc_rd = 0, i_pci_wr = 0;
  logic i_pci_rd = 0, i_autocfg_done = 0, i_autocfg_clear_rst = 0, i_rstout_local_unused = 0;
  logic [11:0] i_loc_addr = 0, i_pci_addr = 0, eng_len = 0;
  logic [3:0] i_loc_be = 0, i_pci_be = 0, eng_gap = 0, o_pci_cmd, ecmd;
  logic [31:0] i_loc_wdata = 0, i_pci_wdata = 0, o_loc_rdata, o_pci_rdata, o_pci_addr;
  logic [31:0] r = 32'h6b143d86, q, lm, pm, lb, hb;
  logic [31:0] ml[2] = '{0, 0}, mp[2] = '{0, 0};
  logic [11:0] ad;
  logic [13:0] o_shared_addr;
  logic i_dphase, o_local_cpu_reset_out, o_local_cpu_reset_out_n, o_soft_reset, o_dq_oe_n;
  logic o_fifo_flush, o_mbox_event_clr, o_xfer_busy, o_xfer_done, o_xfer_dir, cpu_m;
  logic [11:0] tl[5] = '{12'd12, 12'd10, 12'd8, 12'd3, 12'd0};
  logic [1:0] tc[5] = '{2'b00, 2'b10, 2'b00, 2'b01, 2'b00};
  int n_mismatch = 0, n_compared = 0, cyc = 0, n_ph = 0, ph0, i, k, t;
  dmc_top uut (.*);
  dmc_engine_model u_eng (.i_core_clk(i_core_clk), .i_busy(o_xfer_busy), .i_len(eng_len),
    .i_gap(eng_gap), .o_dphase(i_dphase));
  // ****************
  // Clock, phase count, hang guard
  // ****************
  initial forever #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    n_ph += i_dphase;
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // One strobe cycle; op bits are local wr, pci wr, local rd, pci rd
  task automatic bus(input logic [3:0] op, input logic [11:0] a, input logic [3:0] be,
    input logic [31:0] ld, input logic [31:0] pd);
    @(posedge i_core_clk); #1;
    {i_loc_wr, i_pci_wr, i_loc_rd, i_pci_rd} = op;
    {i_loc_addr, i_pci_addr, i_loc_be, i_pci_be} = {a, a, be, be};
    {i_loc_wdata, i_pci_wdata} = {ld, pd};
    @(posedge i_core_clk); #1;
    {i_loc_wr, i_pci_wr, i_loc_rd, i_pci_rd} = 4'h0;
  endtask : bus
  // Extra edge so registered read data has surely landed
  task automatic rd(input logic pci, input logic [11:0] a);
    bus(pci ? 4'h1 : 4'h2, a, 4'hf, 32'h0, 32'h0);
    @(posedge i_core_clk); #1;
    q = pci ? o_pci_rdata : o_loc_rdata;
  endtask : rd
  task automatic wait_done();
    for (t = 0; t < 300 && o_xfer_done !== 1'b1; t++) begin
      @(posedge i_core_clk); #1;
    end
  endtask : wait_done
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (3) @(posedge i_core_clk);
    #1 i_rst_n = 1;
    `CHK({o_local_cpu_reset_out, o_pci_cmd, o_xfer_busy}, 6'b1_0110_0)
    for (i = 0; i < 4; i++) begin
      rd(i[0], i[1] ? DMC_OFF_CONTROL : 12'h4c4);
      `CHK(q, 32'h0)
    end
    // CPU reset bit: held until configuration, then set or cleared by rights
    bus(4'h4, DMC_OFF_HOST_RESET, 4'hf, 0, 0);
    repeat (3) @(posedge i_core_clk);
    `CHK(o_local_cpu_reset_out, 1'b1)
    i_autocfg_done = 1;
    cpu_m = 1;
    for (i = 0; i < 6; i++) begin
      r = lfsr(r);
      i_rstout_local_unused = r[1];
      bus(r[0] ? 4'h4 : 4'h8, DMC_OFF_HOST_RESET, 4'hf, {31'h0, r[2]}, {31'h0, r[2]});
      cpu_m = (r[0] || r[1]) ? r[2] : cpu_m;
      repeat (3) @(posedge i_core_clk);
      `CHK({o_local_cpu_reset_out, o_local_cpu_reset_out_n}, {cpu_m, !cpu_m})
    end
    bus(4'h4, DMC_OFF_HOST_RESET, 4'hf, 0, 32'h1);
    i_autocfg_clear_rst = 1;
    repeat (4) @(posedge i_core_clk);
    `CHK(o_local_cpu_reset_out, 1'b0)
    i_autocfg_clear_rst = 0;
    // Ownership flags written at random from either side
    for (i = 0; i < 24; i++) begin
      r = lfsr(r);
      k = r[0];
      ad = k ? DMC_OFF_CONTROL : DMC_OFF_SEMAPHORE;
      lm = k ? 32'h200 : DMC_SEM_LOC_MASK;
      pm = lm >> 1;
      bus(r[31] ? 4'h4 : 4'h8, ad, k ? 4'h2 : 4'hf, r, r);
      if (r[31]) mp[k] = r & pm & ~(ml[k] >> 1);
      else ml[k] = r & lm & ~(mp[k] << 1);
      rd(r[30], ad);
      `CHK(q & (lm | pm), ml[k] | mp[k])
    end
    // Same-cycle set from both sides on free pairs
    for (k = 0; k < 2; k++) begin
      ad = k ? DMC_OFF_CONTROL : DMC_OFF_SEMAPHORE;
      repeat (2) bus(4'hc, ad, k ? 4'h2 : 4'hf, 0, 0);
      bus(4'hc, ad, k ? 4'h2 : 4'hf, 32'hffff_ffff, 32'hffff_ffff);
      rd(1, ad);
      `CHK(q & 32'h0303_0303, k ? 32'h100 : DMC_SEM_PCI_MASK)
      repeat (2) bus(4'hc, ad, k ? 4'h2 : 4'hf, 0, 0);
    end
    // Clock enable low: a write in that window must leave no trace
    i_ce = 0;
    bus(4'h4, DMC_OFF_LENGTH, 4'hf, 0, 32'h3ffc);
    i_ce = 1;
    rd(1, DMC_OFF_LENGTH);
    `CHK(q, 32'h0)
    // Transfers: lengths around one line, each command and direction
    for (i = 0; i < 5; i++) begin
      r = lfsr(r);
      lb = r & 32'h3ffc;
      hb = lfsr(r) & 32'hffff_fffc;
      bus(4'h8, DMC_OFF_LOCAL_ADDR, 4'hf, lb, 0);
      bus(4'h4, DMC_OFF_HOST_ADDR, 4'hf, 0, hb);
      bus(4'h8, DMC_OFF_LENGTH, 4'hf, {18'h0, tl[i], 2'b00}, 0);
      rd(1, DMC_OFF_LENGTH);
      `CHK(q[13:2], tl[i])
      {eng_len, eng_gap, ph0} = {tl[i], 2'b00, r[5:4], n_ph};
      ecmd = tc[i][0] ? DMC_CMD_MEM_WRITE : (tc[i][1] || tl[i] < 8) ? DMC_CMD_MEM_READ :
        (tl[i] == 8) ? DMC_CMD_READ_LINE : DMC_CMD_READ_MULT;
      bus(4'h8, DMC_OFF_CONTROL, 4'h1, {30'h0, tc[i]}, 0);
      for (t = 0; t < 20 && o_xfer_busy !== 1'b1 && tl[i] != 0; t++) begin
        @(posedge i_core_clk); #1;
      end
      if (tl[i] != 0) begin
        `CHK({o_xfer_busy, o_xfer_dir, o_pci_cmd}, {1'b1, tc[i][0], ecmd})
        `CHK({o_shared_addr, o_pci_addr}, {lb[13:0], hb})
      end
      wait_done();
      `CHK({o_xfer_done, 32'(n_ph - ph0)}, {1'b1, 20'h0, tl[i]})
    end
    // Soft reset keeps direction and prefetch, clears the rest
    bus(4'h8, DMC_OFF_CONTROL, 4'h1, 32'h3, 0);
    wait_done();
    bus(4'h8, DMC_OFF_SEMAPHORE, 4'hf, 32'hffff_ffff, 0);
    bus(4'h4, DMC_OFF_HOST_RESET, 4'hf, 0, 32'h2);
    repeat (3) @(posedge i_core_clk);
    `CHK({o_soft_reset, o_dq_oe_n, o_fifo_flush, o_mbox_event_clr}, 4'hf)
    for (i = 0; i < 3; i++) begin
      rd(i != 1, i == 2 ? DMC_OFF_SEMAPHORE : DMC_OFF_CONTROL);
      `CHK(q, i == 0 ? 32'h3 : 32'h0)
    end
    bus(4'h4, DMC_OFF_HOST_RESET, 4'hf, 0, 0);
    repeat (3) @(posedge i_core_clk);
    rd(0, DMC_OFF_CONTROL);
    `CHK({o_soft_reset, o_fifo_flush, o_mbox_event_clr, o_dq_oe_n, o_local_cpu_reset_out, q},
      {5'b00010, 32'h3})
    stop_test();
  end
endmodule : dmc_top_tb
